// file: rtl/ialbu_pkg.sv
// Package of constants for the integer add, logic and branch unit.
// What this block does
// [RULE1] A register-class opcode with the trapping add function sums the two source words into the third register field.
// [RULE2] A trapping add that overflows 32-bit two's complement writes nothing and raises the overflow exception.
// [RULE3] A trapping add without overflow writes the low 32 bits of the sum, sign-extended to 64 bits.
// [RULE4] Software supplies word add operands whose bits 63 to 31 are all equal, otherwise any result may appear.
// [RULE5] The trapping immediate add sign-extends the immediate, adds it, traps on overflow and else writes the second register field.
// [RULE6] The wrapping immediate add adds the sign-extended immediate modulo 2^32 and writes the sign-extended sum to the second register field.
// [RULE7] The wrapping register add adds the two words modulo 2^32, writes the sign-extended sum and never traps.
// [RULE8] The register conjunction ANDs the full source registers into the destination field with no exception.
// [RULE9] The immediate conjunction zero-extends the immediate, ANDs it with the source and writes the second register field.
// [RULE10] A branch target is the delay-slot address plus the offset shifted left by two and sign-extended from 18 bits.
// [RULE11] Ordinary branches always run the delay slot and redirect control only after it when the condition holds.
// [RULE12] The condition is decided in the branch slot and the program counter changes in the next slot.
// [RULE13] The equal branch is taken when both full source registers are identical.
// [RULE14] The likely equal branch nullifies its delay slot when not taken.
// [RULE15] The register-immediate class with the non-negative selector branches when the source sign bit is clear.
// [RULE16] A nullified instruction changes no architectural state.
// [RULE17] Register zero reads as zero and results aimed at it are discarded.
package ialbu_pkg;
  localparam int XLEN = 64;
  localparam int WLEN = 32;
  localparam int ILEN = 32;
  localparam int RIDX = 5;
  localparam int IMMW = 16;
  localparam int BR_SHIFT = 2;
  localparam logic [5:0] OP_REG_CLASS = 6'h00;
  localparam logic [5:0] OP_REGISTER_IMMEDIATE_CLASS_OPCODE_CLASS = 6'h01;
  localparam logic [5:0] OP_TRAP_IMM_SUM = 6'h08;
  localparam logic [5:0] OP_WRAP_IMM_SUM = 6'h09;
  localparam logic [5:0] OP_IMM_CONJ = 6'h0C;
  localparam logic [5:0] OP_BR_EQUAL = 6'h04;
  localparam logic [5:0] OP_BR_EQUAL_LIKELY = 6'h14;
  localparam logic [5:0] FN_TRAP_WORD_SUM = 6'h20;
  localparam logic [5:0] FN_WRAP_WORD_SUM = 6'h21;
  localparam logic [5:0] FN_REG_CONJ = 6'h24;
  localparam logic [4:0] RI_BR_NONNEG = 5'h01;
  localparam logic [4:0] REG_ZERO = 5'h00;
  localparam logic [XLEN-1:0] PC_STEP = 64'h0000_0000_0000_0004;
  localparam logic [XLEN-1:0] PC_RESET = 64'h0000_0000_0000_0000;
  localparam int OP_HI = 31;
  localparam int OP_LO = 26;
  localparam int RS_HI = 25;
  localparam int RS_LO = 21;
  localparam int RT_HI = 20;
  localparam int RT_LO = 16;
  localparam int RD_HI = 15;
  localparam int RD_LO = 11;
  localparam int FN_HI = 5;
  localparam int FN_LO = 0;
  typedef enum logic [1:0] {
    IALBU_SLOT_NORMAL,
    IALBU_SLOT_DELAY_TAKEN,
    IALBU_SLOT_DELAY_NOT_TAKEN,
    IALBU_SLOT_DELAY_NULLIFY
  } ialbu_slot_t;
endpackage

// file: rtl/ialbu_unit.sv
// Execute stage for word adds, conjunctions and equal/non-negative branches.
`timescale 1ns/10ps
`default_nettype none
module ialbu_unit
  import ialbu_pkg::*;
(
  input  wire logic            clock,
  input  wire logic            rst_b,
  input  wire logic            issue_valid,
  input  wire logic [ILEN-1:0] instr,
  input  wire logic [XLEN-1:0] instr_pc,
  input  wire logic [XLEN-1:0] first_source_data,
  input  wire logic [XLEN-1:0] second_register_data,
  output logic [RIDX-1:0]      first_source_field,
  output logic [RIDX-1:0]      second_register_field,
  output logic                 wb_en,
  output logic [RIDX-1:0]      wb_addr,
  output logic [XLEN-1:0]      wb_data,
  output logic                 overflow_exc,
  output logic                 reserved_instr_exc,
  output logic                 nullified,
  output logic                 pc_redirect,
  output logic [XLEN-1:0]      pc_target
);

  // Timing of the unit, seen from the pipeline around it.
  // An instruction is taken on a rising edge with issue_valid high.
  // Its write-back and exception flags stand for the one cycle that follows that edge.
  // The register file is expected to perform the write at the next edge after that.
  // Exceptions are pulses only; vectoring and the saved program counter belong to the
  // exception logic outside, while the unit itself withholds the write of a faulting result.
  // A branch is decided when it is taken, but fetch is only told to redirect once the
  // delay-slot instruction has been taken as well.
  // Redirecting one slot late keeps the delay-slot instruction alive without any
  // squash path in the fetch logic, at the cost of two registers of pending state, slot_r and target_r.
  // Cycles with issue_valid low are bubbles: they neither advance nor clear the
  // pending delay-slot state, so a stalled front end cannot lose a taken branch.
  // A branch placed in a delay slot has no defined meaning and is not guarded here.
  // The word adds look only at bits 31 to 0 of their operands.
  // Operands that are not sign-extended words give a result that software must not rely on.

  logic [5:0]      opcode;
  logic [5:0]      funct;
  logic [RIDX-1:0] rd_field;
  logic [XLEN-1:0] rs_val;
  logic [XLEN-1:0] rt_val;
  logic [XLEN-1:0] imm_sext;
  logic [XLEN-1:0] imm_zext;
  logic [XLEN-1:0] br_offset;
  logic [XLEN-1:0] sum_b;
  logic [WLEN:0]   word_sum;
  logic            word_ovf;
  logic [XLEN-1:0] word_res;

  ialbu_slot_t     slot_r;
  ialbu_slot_t     slot_nxt;
  logic [XLEN-1:0] target_r;
  logic [XLEN-1:0] target_nxt;
  logic            wb_en_r;
  logic            wb_en_nxt;
  logic [RIDX-1:0] wb_addr_r;
  logic [RIDX-1:0] wb_addr_nxt;
  logic [XLEN-1:0] wb_data_r;
  logic [XLEN-1:0] wb_data_nxt;
  logic            ovf_r;
  logic            ovf_nxt;
  logic            ri_r;
  logic            ri_nxt;
  logic            null_r;
  logic            null_nxt;
  logic            redir_r;
  logic            redir_nxt;
  logic [XLEN-1:0] pct_r;
  logic [XLEN-1:0] pct_nxt;

  // The fields are cut straight from the instruction word.
  // The two source fields also leave the block as register file read addresses,
  // so the read data must arrive in the same cycle as the instruction.
  assign opcode                = instr[OP_HI:OP_LO];
  assign funct                 = instr[FN_HI:FN_LO];
  assign first_source_field    = instr[RS_HI:RS_LO];
  assign second_register_field = instr[RT_HI:RT_LO];
  assign rd_field              = instr[RD_HI:RD_LO];

  // Reads of register zero are forced to zero here so a stale file entry cannot leak.
  assign rs_val = (first_source_field == REG_ZERO) ? '0 : first_source_data; // [RULE17]
  assign rt_val = (second_register_field == REG_ZERO) ? '0 : second_register_data; // [RULE17]

  assign imm_sext  = {{(XLEN-IMMW){instr[IMMW-1]}}, instr[IMMW-1:0]};
  assign imm_zext  = {{(XLEN-IMMW){1'b0}}, instr[IMMW-1:0]}; // [RULE9]
  // Offset shifted by two, sign-extended from 18 bits.
  assign br_offset = {{(XLEN-IMMW-BR_SHIFT){instr[IMMW-1]}},
                      instr[IMMW-1:0], {BR_SHIFT{1'b0}}}; // [RULE10]

  // One shared adder serves all four word add forms.
  // The register forms take the second operand from the register file and the
  // immediate forms take the sign-extended immediate instead.
  // Sharing the adder trades a mux on the second addend for a second carry chain.
  // Only the low word is added; operands with unequal upper bits give an undefined result.
  assign sum_b    = (opcode == OP_REG_CLASS) ? rt_val : imm_sext; // [RULE4]
  assign word_sum = {1'b0, rs_val[WLEN-1:0]} + {1'b0, sum_b[WLEN-1:0]};
  // Overflow when both addends share a sign that the sum does not.
  assign word_ovf = (rs_val[WLEN-1] == sum_b[WLEN-1]) &&
                    (word_sum[WLEN-1] != rs_val[WLEN-1]); // [RULE2]
  assign word_res = {{(XLEN-WLEN){word_sum[WLEN-1]}}, word_sum[WLEN-1:0]}; // [RULE3]

  // Next-state logic for the whole unit.
  // The slot state records what the previous branch decided for the instruction that
  // is about to be taken: run it normally, run it and then redirect, run it with no
  // redirect, or kill it.
  // Every pulse output defaults to low, so each instruction raises its flags for
  // exactly one cycle and a bubble clears them.
  // The write-back address and data hold their last values unless an add or conjunction sets them,
  // which keeps the wide data register from toggling on bubbles.
  always_comb begin
    slot_nxt    = IALBU_SLOT_NORMAL;
    target_nxt  = target_r;
    wb_en_nxt   = 1'b0;
    wb_addr_nxt = wb_addr_r;
    wb_data_nxt = wb_data_r;
    ovf_nxt     = 1'b0;
    ri_nxt      = 1'b0;
    null_nxt    = 1'b0;
    redir_nxt   = 1'b0;
    pct_nxt     = pct_r;
    if (!issue_valid) begin
      // Hold the delay-slot state until the slot instruction actually arrives.
      slot_nxt = slot_r;
    end else begin
      case (slot_r)
        IALBU_SLOT_DELAY_TAKEN: begin
          redir_nxt = 1'b1; // [RULE11]
          pct_nxt   = target_r; // [RULE12]
        end
        IALBU_SLOT_DELAY_NULLIFY: begin
          null_nxt = 1'b1; // [RULE14]
        end
        IALBU_SLOT_DELAY_NOT_TAKEN: begin
          null_nxt = 1'b0; // [RULE11]
        end
        default: begin
          null_nxt = 1'b0;
        end
      endcase
      // A nullified slot instruction is not decoded, so none of its effects take place.
      if (slot_r != IALBU_SLOT_DELAY_NULLIFY) begin // [RULE16]
        case (opcode)
          OP_REG_CLASS: begin
            case (funct)
              FN_TRAP_WORD_SUM: begin
                wb_addr_nxt = rd_field; // [RULE1]
                wb_data_nxt = word_res; // [RULE3]
                wb_en_nxt   = !word_ovf; // [RULE2]
                ovf_nxt     = word_ovf; // [RULE2]
              end
              FN_WRAP_WORD_SUM: begin
                wb_addr_nxt = rd_field;
                wb_data_nxt = word_res; // [RULE7]
                wb_en_nxt   = 1'b1; // [RULE7]
              end
              FN_REG_CONJ: begin
                wb_addr_nxt = rd_field;
                wb_data_nxt = rs_val & rt_val; // [RULE8]
                wb_en_nxt   = 1'b1; // [RULE8]
              end
              default: begin
                wb_en_nxt = 1'b0;
              end
            endcase
          end
          OP_TRAP_IMM_SUM: begin
            wb_addr_nxt = second_register_field; // [RULE5]
            wb_data_nxt = word_res; // [RULE5]
            wb_en_nxt   = !word_ovf; // [RULE5]
            ovf_nxt     = word_ovf; // [RULE5]
          end
          OP_WRAP_IMM_SUM: begin
            wb_addr_nxt = second_register_field; // [RULE6]
            wb_data_nxt = word_res; // [RULE6]
            wb_en_nxt   = 1'b1;
          end
          OP_IMM_CONJ: begin
            wb_addr_nxt = second_register_field;
            wb_data_nxt = rs_val & imm_zext; // [RULE9]
            wb_en_nxt   = 1'b1;
          end
          OP_BR_EQUAL, OP_BR_EQUAL_LIKELY: begin
            target_nxt = instr_pc + PC_STEP + br_offset; // [RULE10]
            if (rs_val == rt_val) begin // [RULE13]
              slot_nxt = IALBU_SLOT_DELAY_TAKEN; // [RULE12]
            end else if (opcode == OP_BR_EQUAL_LIKELY) begin
              slot_nxt = IALBU_SLOT_DELAY_NULLIFY; // [RULE14]
            end else begin
              slot_nxt = IALBU_SLOT_DELAY_NOT_TAKEN; // [RULE11]
            end
          end
          OP_REGISTER_IMMEDIATE_CLASS_OPCODE_CLASS: begin
            if (second_register_field == RI_BR_NONNEG) begin
              target_nxt = instr_pc + PC_STEP + br_offset; // [RULE10]
              slot_nxt   = rs_val[XLEN-1] ? IALBU_SLOT_DELAY_NOT_TAKEN
                                          : IALBU_SLOT_DELAY_TAKEN; // [RULE15]
            end else begin
              ri_nxt = 1'b1;
            end
          end
          default: begin
            ri_nxt = 1'b1;
          end
        endcase
        // Writes aimed at register zero are discarded.
        if (wb_addr_nxt == REG_ZERO) begin // [RULE17]
          wb_en_nxt = 1'b0;
        end
      end
    end
  end

  // Pending branch state.
  // Reset leaves no branch pending, so the first instruction after reset runs normally.
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      slot_r   <= IALBU_SLOT_NORMAL;
      target_r <= PC_RESET;
    end else begin
      slot_r   <= slot_nxt;
      target_r <= target_nxt;
    end
  end

  // Write-back registers.
  // The enable is a pulse, while address and data hold until an add or conjunction sets them.
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      wb_en_r   <= 1'b0;
      wb_addr_r <= REG_ZERO;
      wb_data_r <= '0;
    end else begin
      wb_en_r   <= wb_en_nxt;
      wb_addr_r <= wb_addr_nxt;
      wb_data_r <= wb_data_nxt;
    end
  end

  // Exception and kill pulses.
  // They are registered so that they line up with the write-back they qualify.
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      ovf_r  <= 1'b0;
      ri_r   <= 1'b0;
      null_r <= 1'b0;
    end else begin
      ovf_r  <= ovf_nxt;
      ri_r   <= ri_nxt;
      null_r <= null_nxt;
    end
  end

  // Fetch redirect.
  // The target holds after the pulse, so fetch may sample it one cycle late.
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      redir_r <= 1'b0;
      pct_r   <= PC_RESET;
    end else begin
      redir_r <= redir_nxt;
      pct_r   <= pct_nxt;
    end
  end

  // All outputs except the two source fields come straight from flip-flops.
  // The fields toward the register file are the only combinational outputs.

  assign wb_en              = wb_en_r;
  assign wb_addr            = wb_addr_r;
  assign wb_data            = wb_data_r;
  assign overflow_exc       = ovf_r;
  assign reserved_instr_exc = ri_r;
  assign nullified          = null_r;
  assign pc_redirect        = redir_r;
  assign pc_target          = pct_r;

endmodule
`default_nettype wire

// file: tb/ialbu_monitor.sv
// Port checker for the add, logic and branch unit, bound to its top module.
`timescale 1ns/10ps
`default_nettype none
module ialbu_monitor
  import ialbu_pkg::*;
(
  input wire logic            clock,
  input wire logic            rst_b,
  input wire logic            issue_valid,
  input wire logic [ILEN-1:0] instr,
  input wire logic [XLEN-1:0] instr_pc,
  input wire logic [XLEN-1:0] first_source_data,
  input wire logic [XLEN-1:0] second_register_data,
  input wire logic            wb_en,
  input wire logic [RIDX-1:0] wb_addr,
  input wire logic [XLEN-1:0] wb_data,
  input wire logic            overflow_exc,
  input wire logic            nullified,
  input wire logic            pc_redirect,
  input wire logic [XLEN-1:0] pc_target
);
  // The previous cycle's instruction and operands are kept so each answer is judged against its own cause.
  logic            v_r;
  logic [ILEN-1:0] i_r;
  logic [XLEN-1:0] a_r;
  logic [XLEN-1:0] b_r;
  logic [XLEN-1:0] tgt_r;
  wire logic [5:0] iop = instr[OP_HI:OP_LO];
  always_ff @(posedge clock) begin
    v_r <= issue_valid & rst_b;
    i_r <= instr;
    a_r <= first_source_data;
    b_r <= second_register_data;
    if (issue_valid && iop inside {OP_BR_EQUAL, OP_BR_EQUAL_LIKELY, OP_REGISTER_IMMEDIATE_CLASS_OPCODE_CLASS}) begin
      tgt_r <= instr_pc + PC_STEP + {{46{instr[15]}}, instr[15:0], 2'b00};
    end
  end
  wire logic [5:0]      op = i_r[OP_HI:OP_LO];
  wire logic            rc = (op == OP_REG_CLASS);
  wire logic [RIDX-1:0] dst = rc ? i_r[RD_HI:RD_LO] : i_r[RT_HI:RT_LO];
  wire logic [WLEN-1:0] opb = rc ? b_r[31:0] : {{16{i_r[15]}}, i_r[15:0]};
  wire logic [WLEN-1:0] sum = a_r[31:0] + opb;
  wire logic            ovf = (a_r[31] == opb[31]) && (sum[31] != a_r[31]);
  wire logic            live = v_r && !nullified && dst != REG_ZERO;
  wire logic            trap = op == OP_TRAP_IMM_SUM || (rc && i_r[5:0] == FN_TRAP_WORD_SUM);
  wire logic            wrap = op == OP_WRAP_IMM_SUM || (rc && i_r[5:0] == FN_WRAP_WORD_SUM);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  sequence s_slot;
    issue_valid;
  endsequence
  sequence s_beq_hit;
    issue_valid && iop == OP_BR_EQUAL && first_source_data == second_register_data;
  endsequence
  sequence s_branch_if_equal_likely_miss;
    issue_valid && iop == OP_BR_EQUAL_LIKELY && first_source_data != second_register_data;
  endsequence
  sequence s_nonneg_hit;
    issue_valid && iop == OP_REGISTER_IMMEDIATE_CLASS_OPCODE_CLASS && instr[RT_HI:RT_LO] == RI_BR_NONNEG
      && !first_source_data[63];
  endsequence
  a_trap_overflow: assert property (v_r && !nullified && trap && ovf |-> overflow_exc && !wb_en)
    else $error("trapping add overflow not reported");
  a_trap_result: assert property (live && trap && !ovf |-> wb_en && wb_addr == dst
    && wb_data == {{32{sum[31]}}, sum}) else $error("trapping add result wrong");
  a_wrap_result: assert property (live && wrap |-> wb_en && !overflow_exc && wb_addr == dst
    && wb_data == {{32{sum[31]}}, sum}) else $error("wrapping add result wrong");
  a_zero_dest: assert property (wb_en |-> wb_addr != REG_ZERO)
    else $error("write aimed at register zero");
  a_null_quiet: assert property (nullified |-> !wb_en && !overflow_exc)
    else $error("nullified slot changed state");
  a_redirect_target: assert property (pc_redirect |-> pc_target == tgt_r)
    else $error("branch target wrong");
  a_beq_taken: assert property (s_beq_hit ##1 s_slot |=> pc_redirect)
    else $error("equal branch not taken after slot");
  a_beq_early: assert property (s_beq_hit |=> !pc_redirect)
    else $error("redirect before delay slot");
  a_likely_kill: assert property (s_branch_if_equal_likely_miss ##1 s_slot |=> nullified && !wb_en)
    else $error("likely slot not nullified");
  a_nonneg_taken: assert property (s_nonneg_hit ##1 s_slot |=> pc_redirect)
    else $error("non-negative branch not taken");
endmodule
bind ialbu_unit ialbu_monitor mon_u (
  .clock(clock), .rst_b(rst_b), .issue_valid(issue_valid), .instr(instr),
  .instr_pc(instr_pc), .first_source_data(first_source_data),
  .second_register_data(second_register_data), .wb_en(wb_en), .wb_addr(wb_addr),
  .wb_data(wb_data), .overflow_exc(overflow_exc), .nullified(nullified),
  .pc_redirect(pc_redirect), .pc_target(pc_target)
);
`default_nettype wire

// file: tb/ialbu_regfile_model.sv
// Register file model standing on the far side of the unit.
`timescale 1ns/10ps
`default_nettype none
module ialbu_regfile_model
  import ialbu_pkg::*;
(
  input  wire logic            clock,
  input  wire logic            ld_en,
  input  wire logic [RIDX-1:0] ld_addr,
  input  wire logic [XLEN-1:0] ld_data,
  input  wire logic            wb_en,
  input  wire logic [RIDX-1:0] wb_addr,
  input  wire logic [XLEN-1:0] wb_data,
  input  wire logic [RIDX-1:0] rd_a,
  input  wire logic [RIDX-1:0] rd_b,
  output logic      [XLEN-1:0] q_a,
  output logic      [XLEN-1:0] q_b
);
  logic [XLEN-1:0] mem [0:31];
  // Register zero is hard-wired, so a stray write to it can never read back.
  assign q_a = (rd_a == REG_ZERO) ? '0 : mem[rd_a];
  assign q_b = (rd_b == REG_ZERO) ? '0 : mem[rd_b];
  always @(posedge clock) begin
    if (ld_en) mem[ld_addr] <= ld_data;
    else if (wb_en) mem[wb_addr] <= wb_data;
  end
endmodule
`default_nettype wire

// file: tb/integer_add_logic_branch_unit_tb.sv
// Self-checking bench for the add, logic and branch unit.
`timescale 1ns/10ps
`default_nettype none
module integer_add_logic_branch_unit_tb;
  import ialbu_pkg::*;
  logic            clock = 1'b0;
  logic            rst_b = 1'b0;
  logic            issue_valid = 1'b0;
  logic            ld_en = 1'b0;
  logic [ILEN-1:0] instr = '0;
  logic [XLEN-1:0] instr_pc = '0;
  logic [XLEN-1:0] ld_data = '0;
  logic [RIDX-1:0] ld_addr = '0;
  logic [XLEN-1:0] sa, sb, wb_data, pc_target;
  logic [RIDX-1:0] fa, fb, wb_addr;
  logic            wb_en, overflow_exc, reserved_instr_exc, nullified, pc_redirect;
  int              n_fail = 0;
  int              n_checks = 0;
  always #20 clock = ~clock;
  ialbu_unit dut_u (.clock(clock), .rst_b(rst_b), .issue_valid(issue_valid), .instr(instr),
    .instr_pc(instr_pc), .first_source_data(sa), .second_register_data(sb),
    .first_source_field(fa), .second_register_field(fb), .wb_en(wb_en), .wb_addr(wb_addr),
    .wb_data(wb_data), .overflow_exc(overflow_exc), .reserved_instr_exc(reserved_instr_exc),
    .nullified(nullified), .pc_redirect(pc_redirect), .pc_target(pc_target));
  ialbu_regfile_model rf_u (.clock(clock), .ld_en(ld_en), .ld_addr(ld_addr), .ld_data(ld_data),
    .wb_en(wb_en), .wb_addr(wb_addr), .wb_data(wb_data), .rd_a(fa), .rd_b(fb), .q_a(sa), .q_b(sb));
  function automatic logic [31:0] rr(logic [5:0] fn, logic [4:0] s, logic [4:0] t, logic [4:0] d);
    return {OP_REG_CLASS, s, t, d, 5'h00, fn};
  endfunction
  function automatic logic [31:0] ri(logic [5:0] op, logic [4:0] s, logic [4:0] t, logic [15:0] m);
    return {op, s, t, m};
  endfunction
  task automatic chk(logic [63:0] seen, logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic step(logic [31:0] i, logic [63:0] pc);
    issue_valid = 1'b1;
    instr = i;
    instr_pc = pc;
    @(posedge clock);
    #1;
  endtask
  task automatic idle();
    issue_valid = 1'b0;
    @(posedge clock);
    #1;
  endtask
  // Flags are wb_en, overflow, reserved, nullified and redirect, highest first.
  task automatic flags(logic [4:0] fl, logic [63:0] d);
    chk(64'({wb_en, overflow_exc, reserved_instr_exc, nullified, pc_redirect}), 64'(fl));
    if (fl[4]) chk(wb_data, d);
  endtask
  task automatic one(logic [31:0] i, logic [4:0] fl, logic [63:0] d);
    step(i, 64'h100);
    flags(fl, d);
    idle();
  endtask
  task automatic load(logic [4:0] a, logic [63:0] d);
    ld_en = 1'b1;
    ld_addr = a;
    ld_data = d;
    @(posedge clock);
    #1;
  endtask
  task automatic t_arith();
    one(rr(FN_TRAP_WORD_SUM, 1, 3, 8), 5'h10, 64'h0000_0000_7FFF_FFFA);
    one(rr(FN_TRAP_WORD_SUM, 1, 2, 9), 5'h08, 64'h0);
    one(rr(FN_WRAP_WORD_SUM, 1, 2, 9), 5'h10, 64'hFFFF_FFFF_8000_0000);
    one(ri(OP_TRAP_IMM_SUM, 1, 10, 16'h0001), 5'h08, 64'h0);
    one(ri(OP_TRAP_IMM_SUM, 3, 10, 16'hFFFF), 5'h10, 64'hFFFF_FFFF_FFFF_FFFA);
    one(ri(OP_WRAP_IMM_SUM, 1, 11, 16'h8000), 5'h10, 64'h0000_0000_7FFF_7FFF);
    one(rr(FN_REG_CONJ, 3, 1, 12), 5'h10, 64'h0000_0000_7FFF_FFFB);
    one(ri(OP_IMM_CONJ, 3, 12, 16'h8001), 5'h10, 64'h0000_0000_0000_8001);
    one(rr(FN_WRAP_WORD_SUM, 1, 2, 0), 5'h00, 64'h0);
    one(ri(6'h3F, 1, 2, 16'h0000), 5'h04, 64'h0);
    $display("arithmetic test done");
  endtask
  task automatic t_branch();
    step(ri(OP_BR_EQUAL, 2, 5, 16'h0010), 64'h200);
    flags(5'h00, 64'h0);
    step(rr(FN_WRAP_WORD_SUM, 1, 2, 13), 64'h204);
    flags(5'h11, 64'hFFFF_FFFF_8000_0000);
    chk(pc_target, 64'h244);
    step(ri(OP_BR_EQUAL_LIKELY, 1, 2, 16'h0010), 64'h300);
    step(rr(FN_WRAP_WORD_SUM, 1, 2, 14), 64'h304);
    flags(5'h02, 64'h0);
    step(ri(OP_REGISTER_IMMEDIATE_CLASS_OPCODE_CLASS, 1, RI_BR_NONNEG, 16'hFFFE), 64'h400);
    step(ri(OP_IMM_CONJ, 1, 15, 16'h00FF), 64'h404);
    flags(5'h11, 64'h0000_0000_0000_00FF);
    chk(pc_target, 64'h3FC);
    step(ri(OP_REGISTER_IMMEDIATE_CLASS_OPCODE_CLASS, 3, RI_BR_NONNEG, 16'h0004), 64'h500);
    step(ri(OP_IMM_CONJ, 1, 15, 16'h000F), 64'h504);
    flags(5'h10, 64'h0000_0000_0000_000F);
    idle();
    $display("branch test done");
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clock);
    n_fail++;
    stop_test();
  end
  initial begin
    @(posedge clock);
    #1;
    load(5'h01, 64'h0000_0000_7FFF_FFFF);
    load(5'h02, 64'h0000_0000_0000_0001);
    load(5'h03, 64'hFFFF_FFFF_FFFF_FFFB);
    load(5'h05, 64'h0000_0000_0000_0001);
    ld_en = 1'b0;
    repeat (7) @(posedge clock);
    #1;
    rst_b = 1'b1;
    t_arith();
    t_branch();
    stop_test();
  end
endmodule
`default_nettype wire
